// *** rtl/rpus_pkg.sv ***
// Package with constants shared by the rank power-up sequencer.
package rpus_pkg;
  // ---------------------------------------------------------------
  // Rail layout
  // ---------------------------------------------------------------
  localparam int unsigned NUM_RAILS      = 11;
  localparam int unsigned RANK_W         = 2;
  localparam logic [1:0]  RANK_NONE      = 2'h0;
  localparam logic [1:0]  RANK_FIRST     = 2'h1;
  localparam logic [1:0]  RANK_SECOND    = 2'h2;
  localparam logic [1:0]  RANK_THIRD     = 2'h3;
  // ---------------------------------------------------------------
  // Configuration image layout and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CFG_ADDR_W     = 4;
  localparam int unsigned CFG_DATA_W     = 8;
  localparam int unsigned CFG_RANK_LSB   = 0;
  localparam int unsigned CFG_AUTO_BIT   = 0;
  localparam int unsigned CFG_AUTO_ADDR  = 11;
  localparam int unsigned CFG_I2CA_ADDR  = 12;
  localparam int unsigned CFG_PROT_ADDR  = 13;
  localparam logic [7:0]  CFG_RAIL_RST   = 8'h00;
  localparam logic [7:0]  CFG_AUTO_RST   = 8'h01;
  localparam logic [7:0]  CFG_I2CA_RST   = 8'h33;
  localparam logic [7:0]  CFG_PROT_RST   = 8'h00;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned RANK1_DELAY_MS = 7;
  localparam int unsigned RANK_STEP_MS   = 3;
  localparam int unsigned MS_CYCLES      = CLK_HZ / 1000;
endpackage

// *** rtl/rpus_cfg_store.sv ***
// Non-volatile configuration image with in-system rewrite port.
`timescale 1ns/1ps
module rpus_cfg_store #(
  parameter int unsigned AW = rpus_pkg::CFG_ADDR_W,
  parameter int unsigned DW = rpus_pkg::CFG_DATA_W
) (
  input  wire logic                            mclk_i,
  input  wire logic                            sys_rst_i,
  input  wire logic                            wr_en_i,
  input  wire logic [AW-1:0]                   wr_addr_i,
  input  wire logic [DW-1:0]                   wr_data_i,
  output logic      [(1<<AW)-1:0][DW-1:0]      image_o
);
  // -----------------------------------------------------------------
  // Storage
  // -----------------------------------------------------------------
  // Reset restores the factory image, standing in for a reload from memory cells.
  logic [DW-1:0] mem_ff [(1<<AW)];

  function automatic logic [DW-1:0] factory(input int unsigned a);
    if (a == rpus_pkg::CFG_AUTO_ADDR) begin
      factory = rpus_pkg::CFG_AUTO_RST;
    end else if (a == rpus_pkg::CFG_I2CA_ADDR) begin
      factory = rpus_pkg::CFG_I2CA_RST;
    end else if (a == rpus_pkg::CFG_PROT_ADDR) begin
      factory = rpus_pkg::CFG_PROT_RST;
    end else begin
      factory = rpus_pkg::CFG_RAIL_RST;
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < (1<<AW); g++) begin : g_word
      always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
          mem_ff[g] <= factory(g);
        end else if (wr_en_i && (wr_addr_i == AW'(g))) begin
          mem_ff[g] <= wr_data_i;
        end
      end
      assign image_o[g] = mem_ff[g];
    end
  endgenerate
endmodule

// *** rtl/rpus_sequencer.sv ***
// Rank power-up sequencer top: turn-on detection, delay timer and rail enables.
// Notes on behaviour
// - Start-up is three ranks, each buck or LDO rail takes one rank from configuration.
// - A rank 0 rail is never enabled by the sequence.
// - Rank 1 rails turn on 7 ms after the turn-on condition.
// - Rank 2 rails turn on 3 ms after the rank 1 point.
// - Rank 3 rails turn on 3 ms after the rank 2 point.
// - Boost and power switches are never enabled by the sequence.
// - The automatic power-on option defaults to set.
// - Configuration supplies rail settings, ordering, protection, auto power-on and bus address.
// - Configuration can be rewritten in system over the serial bus by the host.
// - The user power key is active low.
`timescale 1ns/1ps
module rpus_sequencer #(
  parameter int unsigned NRAIL     = rpus_pkg::NUM_RAILS,
  parameter int unsigned MS_CYCLES = rpus_pkg::MS_CYCLES
) (
  input  wire logic                                       mclk_i,
  input  wire logic                                       sys_rst_i,
  input  wire logic                                       host_power_request_i,
  input  wire logic                                       user_power_key_n_i,
  input  wire logic                                       cfg_wr_en_i,
  input  wire logic [rpus_pkg::CFG_ADDR_W-1:0]            cfg_wr_addr_i,
  input  wire logic [rpus_pkg::CFG_DATA_W-1:0]            cfg_wr_data_i,
  output logic      [NRAIL-1:0]                           rail_en_o,
  output logic                                            boost_en_o,
  output logic                                            switch_en_o,
  output logic                                            seq_busy_o,
  output logic                                            seq_done_o,
  output logic      [1:0]                                 rank_reached_o,
  output logic      [rpus_pkg::CFG_DATA_W-1:0]            i2c_target_addr_o,
  output logic      [rpus_pkg::CFG_DATA_W-1:0]            protect_cfg_o
);
  // -----------------------------------------------------------------
  // Configuration image
  // -----------------------------------------------------------------
  localparam int unsigned NW = 1 << rpus_pkg::CFG_ADDR_W;
  localparam int unsigned MS_W = $clog2(MS_CYCLES + 1);

  logic [NW-1:0][rpus_pkg::CFG_DATA_W-1:0] image;

  rpus_cfg_store #(
    .AW (rpus_pkg::CFG_ADDR_W),
    .DW (rpus_pkg::CFG_DATA_W)
  ) i_rpus_cfg_store (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (cfg_wr_en_i),
    .wr_addr_i (cfg_wr_addr_i),
    .wr_data_i (cfg_wr_data_i),
    .image_o   (image)
  );

  wire auto_on = image[rpus_pkg::CFG_AUTO_ADDR][rpus_pkg::CFG_AUTO_BIT];

  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------
  // Both pins start in their released level so reset cannot look like a press.
  logic [1:0] req_sync_ff;
  logic [1:0] key_n_sync_ff;
  logic       req_prev_ff;
  logic       key_prev_ff;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      req_sync_ff   <= 2'h0;
      key_n_sync_ff <= 2'h3;
      req_prev_ff   <= 1'b0;
      key_prev_ff   <= 1'b0;
    end else begin
      req_sync_ff   <= {req_sync_ff[0], host_power_request_i};
      key_n_sync_ff <= {key_n_sync_ff[0], user_power_key_n_i};
      req_prev_ff   <= req_sync_ff[1];
      key_prev_ff   <= ~key_n_sync_ff[1];
    end
  end

  wire req_level = req_sync_ff[1];
  wire key_level = ~key_n_sync_ff[1];
  wire turn_on   = (req_level & ~req_prev_ff) | (key_level & ~key_prev_ff);

  // -----------------------------------------------------------------
  // Sequencer state
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    IDLE,
    RUN,
    DONE
  } rpus_state_e;

  rpus_state_e state_ff;
  rpus_state_e nxt_state;
  logic [MS_W-1:0] tick_ff;
  logic [7:0]      ms_ff;
  logic [1:0]      rank_ff;
  logic [MS_W-1:0] nxt_tick;
  logic [7:0]      nxt_ms;
  logic [1:0]      nxt_rank;

  // -----------------------------------------------------------------
  // Rank marks
  // -----------------------------------------------------------------
  // Eight bits of milliseconds reach the last mark with ample headroom.
  localparam logic [7:0] MS_R1 = 8'(rpus_pkg::RANK1_DELAY_MS);
  localparam logic [7:0] MS_R2 = 8'(rpus_pkg::RANK1_DELAY_MS + rpus_pkg::RANK_STEP_MS);
  localparam logic [7:0] MS_R3 = 8'(rpus_pkg::RANK1_DELAY_MS + 2 * rpus_pkg::RANK_STEP_MS);

  // A rank opens only on the tick that lands on its mark, and only from the rank just below it.
  function automatic logic mark_hit(input logic [7:0] ms,
                                    input logic [7:0] mark,
                                    input logic [1:0] reached,
                                    input logic [1:0] below);
    mark_hit = ((ms + 8'h01) == mark) && (reached == below);
  endfunction

  wire ms_tick  = (tick_ff == MS_W'(MS_CYCLES - 1));
  wire start    = (state_ff == IDLE) && turn_on && auto_on;
  // One timer counts milliseconds from the turn-on event; each rank opens at its own mark.
  wire hit_r1   = ms_tick && mark_hit(ms_ff, MS_R1, rank_ff, rpus_pkg::RANK_NONE);
  wire hit_r2   = ms_tick && mark_hit(ms_ff, MS_R2, rank_ff, rpus_pkg::RANK_FIRST);
  wire hit_r3   = ms_tick && mark_hit(ms_ff, MS_R3, rank_ff, rpus_pkg::RANK_SECOND);

  always_comb begin
    nxt_state = state_ff;
    nxt_tick  = tick_ff;
    nxt_ms    = ms_ff;
    nxt_rank  = rank_ff;
    unique case (state_ff)
      IDLE: begin
        if (start) begin
          nxt_state = RUN;
          nxt_tick  = '0;
          nxt_ms    = 8'h00;
          nxt_rank  = 2'h0;
        end
      end
      RUN: begin
        nxt_tick = ms_tick ? '0 : tick_ff + MS_W'(1);
        if (ms_tick) begin
          nxt_ms = ms_ff + 8'h01;
        end
        // Rank advances by one only, so no rank can be skipped or reordered.
        if (hit_r1 || hit_r2 || hit_r3) begin
          nxt_rank = rank_ff + 2'h1;
        end
        if (hit_r3) begin
          nxt_state = DONE;
        end
      end
      DONE: begin
        nxt_state = DONE;
      end
      // Only a corrupted code lands here; falling back to idle is safer than running on.
      default: begin
        nxt_state = IDLE;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // State registers
  // -----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_ff <= IDLE;
      tick_ff  <= '0;
      ms_ff    <= 8'h00;
      rank_ff  <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      tick_ff  <= nxt_tick;
      ms_ff    <= nxt_ms;
      rank_ff  <= nxt_rank;
    end
  end

  // -----------------------------------------------------------------
  // Rail enables
  // -----------------------------------------------------------------
  function automatic logic rail_due(input logic [1:0] cfg_rank, input logic [1:0] reached);
    rail_due = (cfg_rank != rpus_pkg::RANK_NONE) && (cfg_rank <= reached);
  endfunction

  logic [NRAIL-1:0] nxt_rail_en;

  genvar r;
  generate
    for (r = 0; r < NRAIL; r++) begin : g_rail
      wire [1:0] cfg_rank = image[r][rpus_pkg::CFG_RANK_LSB +: rpus_pkg::RANK_W];
      assign nxt_rail_en[r] = rail_due(cfg_rank, nxt_rank);
    end
  endgenerate

  // Enables latch once set; power-down sequencing is handled elsewhere.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rail_en_o         <= '0;
      boost_en_o        <= 1'b0;
      switch_en_o       <= 1'b0;
      seq_busy_o        <= 1'b0;
      seq_done_o        <= 1'b0;
      rank_reached_o    <= 2'h0;
    end else begin
      rail_en_o         <= rail_en_o | nxt_rail_en;
      boost_en_o        <= 1'b0;
      switch_en_o       <= 1'b0;
      seq_busy_o        <= (nxt_state == RUN);
      seq_done_o        <= (nxt_state == DONE);
      rank_reached_o    <= nxt_rank;
    end
  end

  // -----------------------------------------------------------------
  // Configuration copies
  // -----------------------------------------------------------------
  // Registered so the address and protection outputs never glitch while a word is rewritten.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      i2c_target_addr_o <= rpus_pkg::CFG_I2CA_RST;
      protect_cfg_o     <= rpus_pkg::CFG_PROT_RST;
    end else begin
      i2c_target_addr_o <= image[rpus_pkg::CFG_I2CA_ADDR];
      protect_cfg_o     <= image[rpus_pkg::CFG_PROT_ADDR];
    end
  end
endmodule

// *** verification/rpus_seq_properties.sv ***
// Checker of the sequencer port timing.
`timescale 1ns/1ps
module rpus_seq_chk #(
  parameter int unsigned NRAIL     = rpus_pkg::NUM_RAILS,
  parameter int unsigned MS_CYCLES = rpus_pkg::MS_CYCLES
) (
  input wire logic                            mclk_i,
  input wire logic                            sys_rst_i,
  input wire logic                            cfg_wr_en_i,
  input wire logic [rpus_pkg::CFG_ADDR_W-1:0] cfg_wr_addr_i,
  input wire logic [rpus_pkg::CFG_DATA_W-1:0] cfg_wr_data_i,
  input wire logic [NRAIL-1:0]                rail_en_o,
  input wire logic                            boost_en_o,
  input wire logic                            switch_en_o,
  input wire logic                            seq_busy_o,
  input wire logic                            seq_done_o,
  input wire logic [1:0]                      rank_reached_o
);
  logic [1:0]       rank_ff [NRAIL];
  logic             auto_ff;
  logic             busy_ff;
  logic [1:0]       seen_ff;
  logic [NRAIL-1:0] prev_ff;
  logic [31:0]      gap_ff;
  logic [NRAIL-1:0] bad;
  logic             step;
  assign step = rank_reached_o != seen_ff;
  // Shadow of the rank words, so a rail can be tied to the rank it belongs to.
  always_ff @(posedge mclk_i) begin
    busy_ff <= !sys_rst_i && seq_busy_o;
    seen_ff <= sys_rst_i ? 2'h0 : rank_reached_o;
    prev_ff <= sys_rst_i ? '0 : rail_en_o;
    gap_ff  <= (sys_rst_i || step || (seq_busy_o && !busy_ff)) ? 32'h0 : gap_ff + 32'h1;
    if (sys_rst_i) begin
      auto_ff <= 1'b1;
      for (int i = 0; i < NRAIL; i++) rank_ff[i] <= 2'h0;
    end else if (cfg_wr_en_i) begin
      if (cfg_wr_addr_i < NRAIL) rank_ff[cfg_wr_addr_i] <= cfg_wr_data_i[1:0];
      if (cfg_wr_addr_i == 4'hb) auto_ff <= cfg_wr_data_i[0];
    end
  end
  always_comb begin
    for (int i = 0; i < NRAIL; i++)
      bad[i] = rail_en_o[i] && !prev_ff[i] && (rank_ff[i] == 2'h0 || rank_ff[i] != rank_reached_o);
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_boost_never_on: assert property (!boost_en_o) else $error("boost enabled");
  a_switch_never_on: assert property (!switch_en_o) else $error("switch enabled");
  a_rail_rank_match: assert property (bad == '0) else $error("rail off its rank");
  a_rails_stay_on: assert property ((prev_ff & ~rail_en_o) == '0) else $error("rail dropped");
  a_rank_one_step: assert property (step |-> rank_reached_o == seen_ff + 2'h1)
    else $error("rank skipped");
  a_first_rank_delay: assert property (step && rank_reached_o == 2'h1 |->
    gap_ff inside {[7*MS_CYCLES-3 : 7*MS_CYCLES+1]}) else $error("rank one late");
  a_later_rank_delay: assert property (step && rank_reached_o > 2'h1 |->
    gap_ff inside {[3*MS_CYCLES-2 : 3*MS_CYCLES+1]}) else $error("rank step late");
  a_start_needs_auto: assert property (seq_busy_o && !busy_ff |-> auto_ff) else $error("start without auto");
  a_done_at_top: assert property (seq_done_o |-> rank_reached_o == 2'h3 && !seq_busy_o)
    else $error("done early");
  a_done_holds: assert property (seq_done_o |=> seq_done_o) else $error("done dropped");
endmodule
bind rpus_sequencer rpus_seq_chk #(.NRAIL(NRAIL), .MS_CYCLES(MS_CYCLES)) i_rpus_seq_chk (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cfg_wr_en_i(cfg_wr_en_i), .cfg_wr_addr_i(cfg_wr_addr_i),
  .cfg_wr_data_i(cfg_wr_data_i), .rail_en_o(rail_en_o), .boost_en_o(boost_en_o), .switch_en_o(switch_en_o),
  .seq_busy_o(seq_busy_o), .seq_done_o(seq_done_o), .rank_reached_o(rank_reached_o));

// *** verification/rpus_far_side.sv ***
// Model of the host request pin and the user power key.
`timescale 1ns/1ps
module rpus_far_side (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic host_go_i,
  input  wire logic key_go_i,
  output logic      host_power_request_o,
  output logic      user_power_key_n_o
);
  logic [3:0] hold_ff;
  logic       key_ff;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) hold_ff <= 4'h0;
    else if (host_go_i || key_go_i) hold_ff <= 4'h8;
    else if (hold_ff != 4'h0) hold_ff <= hold_ff - 4'h1;
    if (host_go_i || key_go_i) key_ff <= key_go_i;
  end
  // Released lines fall back to their pull levels, as the real pins do.
  assign host_power_request_o = hold_ff != 4'h0 && !key_ff;
  assign user_power_key_n_o   = !(hold_ff != 4'h0 && key_ff);
endmodule

// *** verification/tb_rpus_sequencer.sv ***
// Self-checking bench of the rank power-up sequencer.
`timescale 1ns/1ps
module tb_rpus_sequencer;
  localparam int unsigned MS = 10;
  localparam int unsigned NR = rpus_pkg::NUM_RAILS;
  logic          mclk_i, sys_rst_i, host_go, key_go, req, key_n, wr_en, boost, sw, busy, done;
  logic [3:0]    wr_addr;
  logic [7:0]    wr_data, i2ca, prot;
  logic [NR-1:0] rail_en;
  logic [1:0]    rank;
  logic [1:0]    ranks [NR];
  logic [31:0]   seed, d;
  int            failures, check_count;
  rpus_far_side i_rpus_far_side (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .host_go_i(host_go),
    .key_go_i(key_go), .host_power_request_o(req), .user_power_key_n_o(key_n));
  rpus_sequencer #(.MS_CYCLES(MS)) i_rpus_sequencer (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .host_power_request_i(req), .user_power_key_n_i(key_n), .cfg_wr_en_i(wr_en), .cfg_wr_addr_i(wr_addr),
    .cfg_wr_data_i(wr_data), .rail_en_o(rail_en), .boost_en_o(boost), .switch_en_o(sw), .seq_busy_o(busy),
    .seq_done_o(done), .rank_reached_o(rank), .i2c_target_addr_o(i2ca), .protect_cfg_o(prot));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [NR-1:0] exp_rails(input logic [1:0] r);
    logic [NR-1:0] v;
    for (int i = 0; i < NR; i++) v[i] = ranks[i] != 2'h0 && ranks[i] <= r;
    return v;
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic wcfg(input logic [3:0] a, input logic [7:0] v);
    wr_en   = 1'b1;
    wr_addr = a;
    wr_data = v;
    tick(1);
    wr_en   = 1'b0;
    tick(1);
  endtask
  task automatic pulse(input bit by_key);
    host_go = !by_key;
    key_go  = by_key;
    tick(1);
    host_go = 1'b0;
    key_go  = 1'b0;
  endtask
  // Random ranks with the upper data bits set at random too; rail 0 and 1 are fixed corners.
  task automatic run(input bit by_key);
    int n, lo, hi;
    for (int i = 0; i < NR; i++) begin
      d = rnd();
      if (i < 2) d[1:0] = i == 0 ? 2'h0 : 2'h3;
      ranks[i] = d[1:0];
      wcfg(i[3:0], d[7:0]);
    end
    pulse(by_key);
    n = 0;
    while (busy !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    chk("start", n <= 6, 1);
    for (int r = 1; r < 4; r++) begin
      lo = r == 1 ? 7*MS-4 : 3*MS-1;
      hi = r == 1 ? 7*MS+1 : 3*MS+1;
      n = 0;
      while (rank !== r[1:0] && n < 100) begin
        tick(1);
        n++;
      end
      chk("rank delay", n >= lo && n <= hi, 1);
      chk("rails", rail_en, exp_rails(r[1:0]));
    end
    chk("done", {done, busy, boost, sw}, 4'h8);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  // Both runs need under 1000 cycles; 5000 leaves ample margin.
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end
  initial begin
    seed        = 32'h39;
    failures    = 0;
    check_count = 0;
    sys_rst_i   = 1'b1;
    host_go     = 1'b0;
    key_go      = 1'b0;
    wr_en       = 1'b0;
    wr_addr     = 4'h0;
    wr_data     = 8'h00;
    tick(10);
    sys_rst_i = 1'b0;
    chk("reset outs", {i2ca, prot, rail_en, busy, rank}, {8'h33, 8'h00, 14'h0});
    wcfg(4'hb, 8'h00);
    wcfg(4'h0, 8'h01);
    pulse(1'b0);
    tick(20);
    chk("auto off", {busy, rail_en}, 0);
    wcfg(4'hb, 8'h01);
    d = rnd();
    wcfg(4'hc, d[7:0]);
    wcfg(4'hd, d[15:8]);
    chk("cfg outs", {i2ca, prot}, {d[7:0], d[15:8]});
    run(1'b0);
    pulse(1'b0);
    tick(20);
    chk("after done", {done, busy, rank}, 4'hb);
    sys_rst_i = 1'b1;
    tick(2);
    sys_rst_i = 1'b0;
    run(1'b1);
    tally_and_finish();
  end
endmodule
